// ===== src/gate_reset_pkg.sv
// Purpose: Constants for the address-line gate and alternate host reset speed-up block.
// Assumes: 100 MHz controller clock; 8-bit firmware and host data paths.
// Notes: Offsets are the printed firmware and host addresses.
// Operation
// - Assist enable picks firmware or host latch
// - Firmware gate register bit 0 drives gate
// - Gate register read returns present gate
// - D1 then data copies bit 1
// - Gate sequence never sets input-full
// - Main power reset sets gate, register 0x01
// - Set and clear strobes drive host latch
// - DF high, DD low, trailing FF ignored
// - Repeated D1 re-enters command-received state
// - Other command or extra data sets input-full
// - Data bytes use only bit 1
// - NAND both reset pulses to host reset
// - 14 us delay then 6 us pulse
// - Bit must clear before next pulse
// - Port at 0x92, resets to 0x00
// - Disabled port ignores writes, floats reads
// - Port bits 7 to 2 read zero
// - Gate pin is OR of both gates
// - Command/data flag follows address bit 2
// - Ordinary writes set input-full, read clears
package gate_reset_pkg;
  localparam int CLOCK_MHZ = 100;
  localparam logic [15:0] FW_GATE_ADDR = 16'h7FFB;
  localparam logic [15:0] FW_SET_ADDR = 16'h7FFE;
  localparam logic [15:0] FW_CLEAR_ADDR = 16'h7FFF;
  localparam logic [15:0] FW_INDATA_ADDR = 16'h7FF1;
  localparam logic [7:0] PORT_ADDR = 8'h92;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] FW_GATE_RESET = 8'h01;
  localparam logic [7:0] CMD_GATE = 8'hD1;
  localparam logic [7:0] CMD_NULL = 8'hFF;
  localparam int GATE_DATA_BIT = 1;
  localparam int PORT_GATE_BIT = 1;
  localparam int PORT_RESET_BIT = 0;
  localparam int RESET_DELAY_US = 14;
  localparam int RESET_PULSE_US = 6;
  localparam int DELAY_CYCLES = RESET_DELAY_US * CLOCK_MHZ;
  localparam int PULSE_CYCLES = RESET_PULSE_US * CLOCK_MHZ;
  localparam int CNT_W = 12;
  typedef enum logic [1:0] {DEC_IDLE, DEC_CMD, DEC_DATA} dec_state_e;
  typedef enum logic [1:0] {RST_IDLE, RST_DELAY, RST_PULSE, RST_DONE} rst_state_e;
endpackage

// ===== src/gate_reset_speedup.sv
// Purpose: Address-line gate and alternate host reset speed-up.
// Assumes: Host and firmware strobes are one-cycle pulses on this clock.
// Notes: Main-supply reset, standby reset and system reset are separate active-low syncs.
//   A host gate data byte beats a firmware strobe landing in the same cycle.
//   Reset delay and pulse widths are fixed counts of the controller clock.
`timescale 1ns/100ps
`default_nettype none
module gate_reset_speedup (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic standbyRst_b,
  input wire logic systemResetOut_b,
  input wire logic firmwareAssistEnable,
  input wire logic portEnable,
  input wire logic hostKbdWrite,
  input wire logic hostAddrBit2,
  input wire logic [7:0] hostWriteData,
  input wire logic hostPortWrite,
  input wire logic hostPortRead,
  input wire logic [7:0] hostPortAddr,
  output logic [7:0] hostPortReadData,
  output logic hostPortReadDrive,
  input wire logic fwWrite,
  input wire logic fwRead,
  input wire logic [15:0] fwAddr,
  input wire logic [7:0] fwWriteData,
  output logic [7:0] fwReadData,
  input wire logic kbdResetPulse_n,
  output logic hostCpuReset,
  output logic addrLineGateOut,
  output logic sharedGatePin,
  output logic inputFullFlag,
  output logic commandDataFlag,
  output logic [7:0] inputData
);
  import gate_reset_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    // Gate latches
    logic hostLatch;
    logic fwLatch;
    // Keyboard decoder and status
    dec_state_e dec;
    logic inputFull;
    logic cmdData;
    logic [7:0] inData;
    // Port register and reset timer
    logic [7:0] port;
    rst_state_e rst;
    logic [CNT_W-1:0] cnt;
    logic altResetPulse_n;
    // Registered firmware read data
    logic [7:0] fwRead;
  } state_s;

  state_s cur;
  state_s next_cur;

  // Address decode shared by read and write paths
  function automatic logic fwHit(input logic [15:0] a, input logic [15:0] target);
    fwHit = (a == target);
  endfunction

  // Command code match, reused by several decoder branches
  function automatic logic isCode(input logic [7:0] d, input logic [7:0] code);
    isCode = (d == code);
  endfunction

  // ============================================================
  // Gate selection
  logic gateNow;

  // Assist enable picks which latch reaches the gate output;
  // the host latch keeps tracking host traffic underneath
  assign gateNow = firmwareAssistEnable ? cur.fwLatch : cur.hostLatch;

  // ============================================================
  // Host keyboard port decode
  logic hostCmdWrite;
  logic hostDataWrite;
  logic gateCmdSeen;
  logic nullCmdSeen;
  logic awaitingData;
  logic gateDataTaken;
  logic hostDataBit;

  // Decoder looks at keyboard writes only; status reads
  // belong to the host interface outside this block
  // Command versus data is split on address bit 2
  assign hostCmdWrite = hostKbdWrite && hostAddrBit2;
  assign hostDataWrite = hostKbdWrite && !hostAddrBit2;
  // Only two command codes steer the decoder
  assign gateCmdSeen = hostCmdWrite && isCode(hostWriteData, CMD_GATE);
  assign nullCmdSeen = hostCmdWrite && isCode(hostWriteData, CMD_NULL);
  // Decoder position
  assign awaitingData = (cur.dec == DEC_CMD);
  // Data byte closing a sequence; the other seven bits are don't care
  assign gateDataTaken = hostDataWrite && awaitingData;
  assign hostDataBit = hostWriteData[GATE_DATA_BIT];

  // ============================================================
  // Firmware register decode
  logic fwGateWrite;
  logic fwGateRead;
  logic fwSetWrite;
  logic fwClearWrite;
  logic fwInDataRead;
  logic strobeBlocked;

  // One hit per mapped address; other addresses
  // belong to neighbouring blocks
  assign fwGateWrite = fwWrite && fwHit(fwAddr, FW_GATE_ADDR);
  assign fwGateRead = fwRead && fwHit(fwAddr, FW_GATE_ADDR);
  assign fwSetWrite = fwWrite && fwHit(fwAddr, FW_SET_ADDR);
  assign fwClearWrite = fwWrite && fwHit(fwAddr, FW_CLEAR_ADDR);
  assign fwInDataRead = fwRead && fwHit(fwAddr, FW_INDATA_ADDR);
  // Latch is shared; a host gate byte landing now beats a strobe
  assign strobeBlocked = gateDataTaken;

  // ============================================================
  // Port register and reset timer decode
  logic portHit;
  logic portWriteHit;
  logic portResetBit;
  logic delayDone;
  logic pulseDone;
  logic portClear;

  // Port answers only when enabled and addressed; reads still see
  // the register, the drive flag alone decides whether the bus is driven
  assign portHit = portEnable && (hostPortAddr == PORT_ADDR);
  assign portWriteHit = hostPortWrite && portHit;
  assign portResetBit = cur.port[PORT_RESET_BIT];
  // Counter starts at zero, so each end point is the count less one
  assign delayDone = (cur.cnt == CNT_W'(DELAY_CYCLES - 1));
  assign pulseDone = (cur.cnt == CNT_W'(PULSE_CYCLES - 1));
  // Standby or system reset empties the port and idles the timer
  assign portClear = !standbyRst_b || !systemResetOut_b;

  // ============================================================
  // Next-state logic
  always_comb begin
    next_cur = cur;
    // Fields not touched below keep their value
    // Every keyboard port write records the byte and its kind
    if (hostKbdWrite) begin
      next_cur.cmdData = hostAddrBit2;
      next_cur.inData = hostWriteData;
    end

    // Gate sequence decoder; recognised bytes never set input-full for firmware
    case (cur.dec)
      DEC_IDLE: begin
        if (gateCmdSeen) begin
          // Sequence opens quietly
          next_cur.dec = DEC_CMD;
        end else if (hostKbdWrite) begin
          // Ordinary traffic is handed to firmware
          next_cur.inputFull = 1'b1;
        end
      end

      DEC_CMD: begin
        if (gateCmdSeen) begin
          // Repeated gate command re-arms without a flag
          next_cur.dec = DEC_CMD;
        end else if (gateDataTaken) begin
          // Data bit 1 goes straight to the host latch
          next_cur.hostLatch = hostDataBit;
          next_cur.dec = DEC_DATA;
        end else if (hostCmdWrite) begin
          // Any other command breaks the sequence
          next_cur.dec = DEC_IDLE;
          next_cur.inputFull = 1'b1;
        end
      end

      DEC_DATA: begin
        if (gateCmdSeen) begin
          // Back to the command state on a repeated gate command
          next_cur.dec = DEC_CMD;
        end else if (nullCmdSeen) begin
          // Trailing null command is swallowed
          next_cur.dec = DEC_IDLE;
        end else if (hostKbdWrite) begin
          // Extra data or a stray command: firmware must know something odd happened
          next_cur.dec = DEC_IDLE;
          next_cur.inputFull = 1'b1;
        end
      end

      default: begin
        // Unused encoding recovers to idle
        next_cur.dec = DEC_IDLE;
      end
    endcase

    // Input-data read empties the buffer; a host write in the same cycle wins
    if (fwInDataRead && !hostKbdWrite) begin
      next_cur.inputFull = 1'b0;
    end

    // Firmware strobes on the host latch; written data is ignored
    if (!strobeBlocked) begin
      if (fwSetWrite) begin
        next_cur.hostLatch = 1'b1;
      end
      if (fwClearWrite) begin
        next_cur.hostLatch = 1'b0;
      end
    end

    // Firmware gate latch keeps bit 0 only
    if (fwGateWrite) begin
      next_cur.fwLatch = fwWriteData[0];
    end

    // Firmware read data, registered; idle cycles return zero
    next_cur.fwRead = 8'h00;
    if (fwGateRead) begin
      // Present gate output, upper bits zero
      next_cur.fwRead = {7'h00, gateNow};
    end else if (fwInDataRead) begin
      // Last host byte, command or data
      next_cur.fwRead = cur.inData;
    end

    // Port register: reserved bits are never stored, so they read zero
    if (portWriteHit) begin
      // Bit 1 feeds the gate pin, bit 0 the reset timer
      next_cur.port = {6'h00, hostWriteData[PORT_GATE_BIT], hostWriteData[PORT_RESET_BIT]};
    end

    // Alternate reset timer; DONE waits for the bit to drop.
    // Whole clock periods are counted, so the minimum widths are met exactly
    case (cur.rst)
      RST_IDLE: begin
        // Line held high while idle
        next_cur.altResetPulse_n = 1'b1;
        if (portResetBit) begin
          // A set bit starts the delay from zero
          next_cur.rst = RST_DELAY;
          next_cur.cnt = '0;
        end
      end

      RST_DELAY: begin
        next_cur.cnt = cur.cnt + 1'b1;
        if (delayDone) begin
          // Delay over: open the low pulse
          next_cur.rst = RST_PULSE;
          next_cur.cnt = '0;
          next_cur.altResetPulse_n = 1'b0;
        end
      end

      RST_PULSE: begin
        next_cur.cnt = cur.cnt + 1'b1;
        if (pulseDone) begin
          // Pulse width met: release the line
          next_cur.rst = RST_DONE;
          next_cur.altResetPulse_n = 1'b1;
        end
      end

      RST_DONE: begin
        // Toggling during a pulse cannot retrigger: re-arm only here
        if (!portResetBit) begin
          next_cur.rst = RST_IDLE;
        end
      end

      default: begin
        // Unused encoding recovers to idle
        next_cur.rst = RST_IDLE;
      end
    endcase

    // Standby and system reset clear only the port and its timer
    if (portClear) begin
      next_cur.port = PORT_RESET;
      next_cur.rst = RST_IDLE;
      next_cur.cnt = '0;
      next_cur.altResetPulse_n = 1'b1;
    end
  end

  // ============================================================
  // Registers; main-supply reset
  // Only main-supply reset touches the latches and the decoder;
  // the other two resets act through the next-state logic
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      // Gate comes up open
      cur.hostLatch <= 1'b1;
      cur.fwLatch <= FW_GATE_RESET[0];
      // Decoder and keyboard status empty
      cur.dec <= DEC_IDLE;
      cur.inputFull <= 1'b0;
      cur.cmdData <= 1'b0;
      cur.inData <= 8'h00;
      // Port and timer quiet
      cur.port <= PORT_RESET;
      cur.rst <= RST_IDLE;
      cur.cnt <= '0;
      cur.altResetPulse_n <= 1'b1;
      // No read data pending
      cur.fwRead <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // ============================================================
  // Outputs
  // Gate output and pin: the port bit can only add a high, never mask one
  assign addrLineGateOut = gateNow;
  assign sharedGatePin = gateNow | cur.port[PORT_GATE_BIT];

  // Host reset: either active-low pulse raises it; combinational so the
  // keyboard pulse passes with no added latency
  assign hostCpuReset = ~(cur.altResetPulse_n & kbdResetPulse_n);

  // Port read path; the drive flag lets the host bus float when disabled
  assign hostPortReadDrive = hostPortRead && portHit;
  assign hostPortReadData = cur.port;

  // Firmware read data straight from its flip-flops
  assign fwReadData = cur.fwRead;

  // Keyboard status and input buffer, all registered
  assign inputFullFlag = cur.inputFull;
  assign commandDataFlag = cur.cmdData;
  assign inputData = cur.inData;
endmodule // gate_reset_speedup
`default_nettype wire

// ===== sim/gate_reset_checker.sv
// Purpose: Port-level checks for the gate and reset speed-up.
// Assumes: Sees only top-level ports.
// Notes: Pulse checks look over 8-cycle windows, not the full 1400/600.
`timescale 1ns/100ps
`default_nettype none
module gate_reset_checker (
  input wire logic clock, rst_b, portEnable, hostKbdWrite, hostAddrBit2, hostPortRead,
  input wire logic [7:0] hostPortAddr, hostPortReadData, fwReadData,
  input wire logic hostPortReadDrive, fwRead, kbdResetPulse_n, hostCpuReset,
  input wire logic [15:0] fwAddr,
  input wire logic addrLineGateOut, sharedGatePin, commandDataFlag
);
  // ====
  // Checks on the controller clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_cd; hostKbdWrite |=> commandDataFlag == $past(hostAddrBit2); endproperty
  a_cd: assert property (p_cd) else $error("cd flag");
  property p_drv; hostPortReadDrive == (hostPortRead && portEnable && hostPortAddr == 8'h92); endproperty
  a_drv: assert property (p_drv) else $error("port drive");
  property p_rsv; hostPortReadData[7:2] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_pin; sharedGatePin == (addrLineGateOut | hostPortReadData[1]); endproperty
  a_pin: assert property (p_pin) else $error("gate pin");
  property p_nand; !kbdResetPulse_n |-> hostCpuReset; endproperty
  a_nand: assert property (p_nand) else $error("reset nand");
  property p_rd; fwRead && fwAddr == 16'h7FFB |=> fwReadData == {7'h00, $past(addrLineGateOut)}; endproperty
  a_rd: assert property (p_rd) else $error("gate read");
  property p_dly; $rose(hostPortReadData[0]) && kbdResetPulse_n && !hostCpuReset |-> !hostCpuReset [*8]; endproperty
  a_dly: assert property (p_dly) else $error("early pulse");
  property p_wid; $rose(hostCpuReset) && kbdResetPulse_n |-> hostCpuReset [*8]; endproperty
  a_wid: assert property (p_wid) else $error("short pulse");
  c_pulse: cover property ($rose(hostCpuReset));
  c_gate: cover property ($fell(addrLineGateOut));
  c_port: cover property (hostPortReadDrive);
endmodule // gate_reset_checker
bind gate_reset_speedup gate_reset_checker chk (.*);
`default_nettype wire

// ===== sim/host_io_model.sv
// Purpose: Host chipset model issuing keyboard and port I/O cycles.
// Assumes: One-cycle strobes on the controller clock.
// Notes: Released write data shows the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module host_io_model (
  input wire logic clock,
  output logic hostKbdWrite, hostAddrBit2, hostPortWrite, hostPortRead,
  output logic [7:0] hostWriteData, hostPortAddr,
  input wire logic [7:0] hostPortReadData,
  input wire logic hostPortReadDrive
);
  // ====
  // Idle bus at time zero
  initial begin
    {hostKbdWrite, hostAddrBit2, hostPortWrite, hostPortRead, hostWriteData, hostPortAddr} = 0;
  end
  // Keyboard write; address bit 2 high marks a command
  task automatic kbd(input logic cmd, input logic [7:0] d);
    @(posedge clock); hostKbdWrite <= 1; hostAddrBit2 <= cmd; hostWriteData <= d;
    @(posedge clock); hostKbdWrite <= 0; hostWriteData <= ~d;
    #1;
  endtask
  // I/O cycle; q is drive flag and read byte, taken at the strobe's edge
  task automatic port(input logic wr, input logic [7:0] a, d, output logic [8:0] q);
    @(posedge clock); hostPortWrite <= wr; hostPortRead <= !wr; hostPortAddr <= a; hostWriteData <= d;
    @(posedge clock); q = {hostPortReadDrive, hostPortReadData};
    hostPortWrite <= 0; hostPortRead <= 0; hostWriteData <= ~d;
    #1;
  endtask
endmodule // host_io_model
`default_nettype wire

// ===== sim/a20_gate_and_cpu_reset_speedup_tb.sv
// Purpose: Self-checking bench for the gate and reset speed-up.
// Assumes: Host cycles come from host_io_model.
// Notes: Pulse timing is counted in clock cycles after the port write.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module a20_gate_and_cpu_reset_speedup_tb;
  import gate_reset_pkg::*;
  logic clock = 0, rst_b = 0, systemResetOut_b = 1, standbyRst_b = 1, firmwareAssistEnable = 0, portEnable = 0;
  logic fwWrite = 0, fwRead = 0, kbdResetPulse_n = 1, prev;
  logic hostKbdWrite, hostAddrBit2, hostPortWrite, hostPortRead, hostPortReadDrive, hostCpuReset;
  logic addrLineGateOut, sharedGatePin, inputFullFlag, commandDataFlag;
  logic [15:0] fwAddr = 0;
  logic [7:0] fwWriteData = 0, fwReadData, hostWriteData, hostPortAddr, hostPortReadData, inputData;
  logic [8:0] q;
  int compares = 0, failures = 0, ticks = 0, rises, dly, wid;
  host_io_model host (.*);
  gate_reset_speedup uut (.*);
  // ====
  // Clock and hang guard; the run needs about 7200 cycles
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    ticks++;
    if (ticks == 20000) begin failures++; test_done(); end
  end
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Firmware access; read data is valid the cycle after the strobe
  task automatic fw(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock); fwRead <= rd; fwWrite <= !rd; fwAddr <= a; fwWriteData <= d;
    @(posedge clock); fwRead <= 0; fwWrite <= 0;
    #1;
  endtask
  // Counts reset pulses, cycles before the first, and high cycles
  task automatic watch(input int n);
    rises = 0; dly = 0; wid = 0; prev = hostCpuReset;
    repeat (n) begin
      @(posedge clock); #1;
      if (hostCpuReset && !prev) rises++;
      if (rises == 0) dly++;
      if (hostCpuReset) wid++;
      prev = hostCpuReset;
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1;
    fw(1, FW_GATE_ADDR, 0); `CHK({fwReadData, addrLineGateOut}, 9'h003)
    firmwareAssistEnable <= 1; fw(1, FW_GATE_ADDR, 0); `CHK(fwReadData, 8'h01)
    firmwareAssistEnable <= 0;
    host.kbd(1, CMD_GATE); host.kbd(0, 8'hDD); `CHK({addrLineGateOut, inputFullFlag}, 2'b00)
    host.kbd(1, CMD_NULL); `CHK({addrLineGateOut, inputFullFlag, commandDataFlag}, 3'b001)
    host.kbd(1, CMD_GATE); host.kbd(1, CMD_GATE); host.kbd(0, 8'h02); `CHK({addrLineGateOut, inputFullFlag}, 2'b10)
    host.kbd(1, CMD_GATE); host.kbd(1, 8'hAD); `CHK({addrLineGateOut, inputFullFlag, inputData}, 10'h3AD)
    fw(1, FW_INDATA_ADDR, 0); `CHK({fwReadData, inputFullFlag}, 9'h15A)
    host.kbd(1, CMD_GATE); host.kbd(0, 8'hDF); host.kbd(0, 8'h00); `CHK({addrLineGateOut, inputFullFlag, commandDataFlag}, 3'b110)
    fw(0, FW_CLEAR_ADDR, 8'hFF); fw(1, FW_GATE_ADDR, 0); `CHK(fwReadData, 8'h00)
    fw(0, FW_SET_ADDR, 8'h00); `CHK(addrLineGateOut, 1'b1)
    firmwareAssistEnable <= 1; fw(0, FW_GATE_ADDR, 8'hFE); `CHK(addrLineGateOut, 1'b0)
    firmwareAssistEnable <= 0; fw(1, FW_GATE_ADDR, 0); `CHK(fwReadData, 8'h01)
    host.port(1, PORT_ADDR, 8'h03, q); host.port(0, PORT_ADDR, 0, q); `CHK(q[8], 1'b0)
    portEnable <= 1; host.port(0, PORT_ADDR, 0, q); `CHK(q, 9'h100)
    host.port(1, PORT_ADDR, 8'hFE, q); host.port(0, PORT_ADDR, 0, q); `CHK(q, 9'h102)
    fw(0, FW_CLEAR_ADDR, 0); `CHK(sharedGatePin, 1'b1)
    host.port(1, PORT_ADDR, 8'h00, q); `CHK(sharedGatePin, 1'b0)
    host.port(1, PORT_ADDR, 8'h01, q); watch(100); host.port(1, PORT_ADDR, 8'h00, q);
    host.port(1, PORT_ADDR, 8'h01, q); watch(2600); `CHK(rises, 1)
    host.port(1, PORT_ADDR, 8'h00, q); host.port(1, PORT_ADDR, 8'h01, q); watch(2200);
    `CHK({rises == 1, dly >= 1399 && dly <= 1402, wid >= 600}, 3'b111)
    host.port(1, PORT_ADDR, 8'h01, q); watch(2200); `CHK(rises, 0)
    @(posedge clock); kbdResetPulse_n <= 0; #1 `CHK(hostCpuReset, 1'b1)
    @(posedge clock); kbdResetPulse_n <= 1; systemResetOut_b <= 0;
    @(posedge clock); systemResetOut_b <= 1; host.port(0, PORT_ADDR, 0, q); `CHK(q, 9'h100)
    host.port(1, PORT_ADDR, 8'h02, q); `CHK(sharedGatePin, 1'b1)
    @(posedge clock); standbyRst_b <= 0;
    @(posedge clock); standbyRst_b <= 1; host.port(0, PORT_ADDR, 0, q); `CHK({q, sharedGatePin}, 10'h200)
    test_done();
  end
endmodule // a20_gate_and_cpu_reset_speedup_tb
`default_nettype wire
